// >>> hw/mac_stat_consts.vh
`ifndef MAC_STAT_CONSTS_VH
`define MAC_STAT_CONSTS_VH
// Register byte addresses
`define OFF_EXCESS_COL 12'h000
`define OFF_TX_UNDERRUN 12'h004
`define OFF_CARRIER_ERR 12'h008
`define OFF_RX_RESOURCE 12'h00C
`define OFF_RX_OVERRUN 12'h010
`define OFF_SYMBOL_ERR 12'h014
`define OFF_EXCESS_LEN 12'h018
`define OFF_JABBER 12'h01C
`define OFF_UNDERSIZE 12'h020
`define OFF_SQE_ERR 12'h024
`define OFF_LEN_MISMATCH 12'h028
`define OFF_CFG 12'h02C
`define OFF_IRQ_STAT 12'h030
`define OFF_IRQ_MASK 12'h034
// Configuration register fields
`define CFG_BIG_BIT 8
`define CFG_LEN_CHK_BIT 16
`define CFG_HALF_DUP_BIT 0
`define CFG_RESET 32'h00000000
`define CNT_RESET 16'h0000
// Frame length limits in bytes
`define LEN_MIN 14'd64
`define LEN_MAX 14'd1518
`define LEN_MAX_BIG 14'd1536
`define TYPE_MIN 16'h0600
// SQE window: 96 bit times, in ns per bit (10 Mb/s half duplex)
`define SQE_BITS 96
`define BIT_TIME_NS 100
`define CLK_PERIOD_NS 5
`define SQE_CYCLES ((`SQE_BITS * `BIT_TIME_NS) / `CLK_PERIOD_NS)
`endif

// >>> hw/mac_error_statistics_counters.v
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "mac_stat_consts.vh"
module mac_error_statistics_counters #(
	parameter SQE_CYCLES = `SQE_CYCLES
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire tx_done,
	input wire tx_excess_col,
	input wire tx_underrun,
	input wire tx_any_col,
	input wire tx_crs_lost,
	input wire tx_en,
	input wire col,
	input wire rx_done,
	input wire rx_addr_match,
	input wire rx_no_buffer,
	input wire rx_overrun,
	input wire rx_symbol_err,
	input wire rx_crc_err,
	input wire rx_align_err,
	input wire [13:0] rx_length,
	input wire [15:0] rx_len_type,
	output wire fcs_align_err,
	output wire irq
);
	localparam NCNT = 11;
	// Counter values as they read back
	wire [7:0] excessive_collision_count;
	wire [7:0] transmit_underrun_count;
	wire [7:0] carrier_sense_error_count;
	wire [15:0] receive_resource_error_count;
	wire [7:0] receive_overrun_count;
	wire [7:0] receive_symbol_error_count;
	wire [7:0] excessive_length_count;
	wire [7:0] receive_jabber_count;
	wire [7:0] undersize_frame_count;
	wire [7:0] sqe_test_error_count;
	wire [7:0] length_field_mismatch_count;
	wire [NCNT-1:0] load;
	reg [31:0] cfg_r;
	reg [NCNT-1:0] stat_r;
	reg [NCNT-1:0] mask_r;
	reg tx_en_s1_r, tx_en_s2_r, col_s1_r, col_s2_r, tx_en_d_r;
	reg sqe_wait_r;
	reg [15:0] sqe_cnt_r;
	reg [NCNT-1:0] inc;
	reg [31:0] rd_data;
	reg rd_hit;
	wire half_dup;
	wire [13:0] max_len;
	wire too_long, too_short, any_err, fcs_len_ok;
	wire sqe_start, sqe_fail;
	wire acc, wr_acc, rd_acc;

	assign half_dup = cfg_r[`CFG_HALF_DUP_BIT];
	assign max_len = cfg_r[`CFG_BIG_BIT] ? `LEN_MAX_BIG : `LEN_MAX;
	assign too_long = rx_length > max_len;
	assign too_short = rx_length < `LEN_MIN;
	assign any_err = rx_crc_err | rx_align_err | rx_symbol_err;
	// Frame of valid length with an error goes to the FCS/alignment counters outside
	assign fcs_len_ok = !too_long && !too_short;
	assign fcs_align_err = rx_done && any_err && fcs_len_ok;

	// MII levels come from outside the clock domain
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_en_s1_r <= 1'b0;
			tx_en_s2_r <= 1'b0;
			col_s1_r <= 1'b0;
			col_s2_r <= 1'b0;
			tx_en_d_r <= 1'b0;
		end else begin
			tx_en_s1_r <= tx_en;
			tx_en_s2_r <= tx_en_s1_r;
			col_s1_r <= col;
			col_s2_r <= col_s1_r;
			tx_en_d_r <= tx_en_s2_r;
		end
	end

	assign sqe_start = tx_en_d_r && !tx_en_s2_r && half_dup;
	assign sqe_fail = sqe_wait_r && !col_s2_r && (sqe_cnt_r == 16'd1);

	// Watch for collision within the interframe gap after transmit ends
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sqe_wait_r <= 1'b0;
			sqe_cnt_r <= 16'h0000;
		end else if (sqe_start) begin
			sqe_wait_r <= 1'b1;
			sqe_cnt_r <= SQE_CYCLES[15:0];
		end else if (sqe_wait_r) begin
			if (col_s2_r || sqe_cnt_r == 16'd1)
				sqe_wait_r <= 1'b0;
			sqe_cnt_r <= sqe_cnt_r - 16'd1;
		end
	end

	always @* begin
		inc = {NCNT{1'b0}};
		if (tx_done) begin
			if (tx_underrun) begin
				inc[1] = 1'b1;
			end else begin
				inc[0] = tx_excess_col;
				inc[2] = half_dup && !tx_any_col && tx_crs_lost;
			end
		end
		if (rx_done) begin
			inc[3] = rx_addr_match && rx_no_buffer;
			inc[4] = rx_addr_match && rx_overrun;
			inc[5] = rx_symbol_err;
			inc[6] = too_long && !any_err;
			inc[7] = too_long && any_err;
			inc[8] = too_short && !any_err;
			inc[10] = cfg_r[`CFG_LEN_CHK_BIT] && rx_len_type < `TYPE_MIN && !too_long
				&& {2'b00, rx_length} < rx_len_type;
		end
		inc[9] = sqe_fail;
	end

	assign acc = psel && penable;
	assign wr_acc = acc && pwrite;
	assign rd_acc = acc && !pwrite;
	assign pready = 1'b1;
	assign pslverr = acc && !rd_hit;
	assign irq = |(stat_r & mask_r);

	// Register map: every mapped offset reads back, others raise pslverr
	always @* begin
		rd_hit = 1'b1;
		rd_data = 32'h00000000;
		if (paddr == `OFF_EXCESS_COL) begin
			rd_data = {24'h000000, excessive_collision_count};
		end else if (paddr == `OFF_TX_UNDERRUN) begin
			rd_data = {24'h000000, transmit_underrun_count};
		end else if (paddr == `OFF_CARRIER_ERR) begin
			rd_data = {24'h000000, carrier_sense_error_count};
		end else if (paddr == `OFF_RX_RESOURCE) begin
			rd_data = {16'h0000, receive_resource_error_count};
		end else if (paddr == `OFF_RX_OVERRUN) begin
			rd_data = {24'h000000, receive_overrun_count};
		end else if (paddr == `OFF_SYMBOL_ERR) begin
			rd_data = {24'h000000, receive_symbol_error_count};
		end else if (paddr == `OFF_EXCESS_LEN) begin
			rd_data = {24'h000000, excessive_length_count};
		end else if (paddr == `OFF_JABBER) begin
			rd_data = {24'h000000, receive_jabber_count};
		end else if (paddr == `OFF_UNDERSIZE) begin
			rd_data = {24'h000000, undersize_frame_count};
		end else if (paddr == `OFF_SQE_ERR) begin
			rd_data = {24'h000000, sqe_test_error_count};
		end else if (paddr == `OFF_LEN_MISMATCH) begin
			rd_data = {24'h000000, length_field_mismatch_count};
		end else if (paddr == `OFF_CFG) begin
			rd_data = cfg_r;
		end else if (paddr == `OFF_IRQ_STAT) begin
			rd_data = {{(32-NCNT){1'b0}}, stat_r};
		end else if (paddr == `OFF_IRQ_MASK) begin
			rd_data = {{(32-NCNT){1'b0}}, mask_r};
		end else begin
			rd_hit = 1'b0;
		end
	end

	// Counters: a write loads and wins over a same-cycle event; they wrap at full scale
	assign load[0] = wr_acc && paddr == `OFF_EXCESS_COL;
	assign load[1] = wr_acc && paddr == `OFF_TX_UNDERRUN;
	assign load[2] = wr_acc && paddr == `OFF_CARRIER_ERR;
	assign load[3] = wr_acc && paddr == `OFF_RX_RESOURCE;
	assign load[4] = wr_acc && paddr == `OFF_RX_OVERRUN;
	assign load[5] = wr_acc && paddr == `OFF_SYMBOL_ERR;
	assign load[6] = wr_acc && paddr == `OFF_EXCESS_LEN;
	assign load[7] = wr_acc && paddr == `OFF_JABBER;
	assign load[8] = wr_acc && paddr == `OFF_UNDERSIZE;
	assign load[9] = wr_acc && paddr == `OFF_SQE_ERR;
	assign load[10] = wr_acc && paddr == `OFF_LEN_MISMATCH;

	stat_counter #(
		.WIDTH(8)
	) u_excess_col (
		.pclk(pclk),
		.presetn(presetn),
		.load(load[0]),
		.load_value(pwdata[7:0]),
		.bump(inc[0]),
		.count_r(excessive_collision_count)
	);

	stat_counter #(
		.WIDTH(8)
	) u_tx_underrun (
		.pclk(pclk),
		.presetn(presetn),
		.load(load[1]),
		.load_value(pwdata[7:0]),
		.bump(inc[1]),
		.count_r(transmit_underrun_count)
	);

	stat_counter #(
		.WIDTH(8)
	) u_carrier_err (
		.pclk(pclk),
		.presetn(presetn),
		.load(load[2]),
		.load_value(pwdata[7:0]),
		.bump(inc[2]),
		.count_r(carrier_sense_error_count)
	);

	// The receive resource counter is the only 16-bit one
	stat_counter #(
		.WIDTH(16)
	) u_rx_resource (
		.pclk(pclk),
		.presetn(presetn),
		.load(load[3]),
		.load_value(pwdata[15:0]),
		.bump(inc[3]),
		.count_r(receive_resource_error_count)
	);

	stat_counter #(
		.WIDTH(8)
	) u_rx_overrun (
		.pclk(pclk),
		.presetn(presetn),
		.load(load[4]),
		.load_value(pwdata[7:0]),
		.bump(inc[4]),
		.count_r(receive_overrun_count)
	);

	stat_counter #(
		.WIDTH(8)
	) u_symbol_err (
		.pclk(pclk),
		.presetn(presetn),
		.load(load[5]),
		.load_value(pwdata[7:0]),
		.bump(inc[5]),
		.count_r(receive_symbol_error_count)
	);

	stat_counter #(
		.WIDTH(8)
	) u_excess_len (
		.pclk(pclk),
		.presetn(presetn),
		.load(load[6]),
		.load_value(pwdata[7:0]),
		.bump(inc[6]),
		.count_r(excessive_length_count)
	);

	stat_counter #(
		.WIDTH(8)
	) u_jabber (
		.pclk(pclk),
		.presetn(presetn),
		.load(load[7]),
		.load_value(pwdata[7:0]),
		.bump(inc[7]),
		.count_r(receive_jabber_count)
	);

	stat_counter #(
		.WIDTH(8)
	) u_undersize (
		.pclk(pclk),
		.presetn(presetn),
		.load(load[8]),
		.load_value(pwdata[7:0]),
		.bump(inc[8]),
		.count_r(undersize_frame_count)
	);

	stat_counter #(
		.WIDTH(8)
	) u_sqe_err (
		.pclk(pclk),
		.presetn(presetn),
		.load(load[9]),
		.load_value(pwdata[7:0]),
		.bump(inc[9]),
		.count_r(sqe_test_error_count)
	);

	stat_counter #(
		.WIDTH(8)
	) u_len_mismatch (
		.pclk(pclk),
		.presetn(presetn),
		.load(load[10]),
		.load_value(pwdata[7:0]),
		.bump(inc[10]),
		.count_r(length_field_mismatch_count)
	);

	// Sticky event bits: a read clears only the bits it returned, so an event
	// landing between setup and access survives; a new event wins over the clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r <= `CFG_RESET;
			stat_r <= {NCNT{1'b0}};
			mask_r <= {NCNT{1'b0}};
		end else begin
			if (wr_acc && paddr == `OFF_CFG)
				cfg_r <= pwdata;
			if (wr_acc && paddr == `OFF_IRQ_MASK)
				mask_r <= pwdata[NCNT-1:0];
			if (rd_acc && paddr == `OFF_IRQ_STAT)
				stat_r <= (stat_r & ~prdata[NCNT-1:0]) | inc;
			else
				stat_r <= stat_r | inc;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel && !penable && !pwrite)
			prdata <= rd_data;
	end
endmodule // mac_error_statistics_counters

// One statistics counter: reset, software load, then count with wrap
module stat_counter #(
	parameter WIDTH = 8
) (
	input wire pclk,
	input wire presetn,
	input wire load,
	input wire [WIDTH-1:0] load_value,
	input wire bump,
	output reg [WIDTH-1:0] count_r
);
	localparam [15:0] RESET_VALUE = `CNT_RESET;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			count_r <= RESET_VALUE[WIDTH-1:0];
		else if (load)
			count_r <= load_value;
		else if (bump)
			count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
	end
endmodule // stat_counter

// >>> test/mac_stat_chk.sv
`timescale 1ns/1ps
module mac_stat_chk (
	input wire pclk, presetn, psel, penable, pwrite, pslverr, irq,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire rx_done, rx_symbol_err, fcs_align_err,
	input wire [13:0] rx_length
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd = psel & penable & !pwrite;
	wire sym = rx_done & rx_symbol_err;
	property p_col_width; rd && paddr == 12'h000 |-> prdata[31:8] == 24'h0; endproperty
	a_col_width: assert property (p_col_width) else $error("collision count too wide");
	property p_res_width; rd && paddr == 12'h00C |-> prdata[31:16] == 16'h0; endproperty
	a_res_width: assert property (p_res_width) else $error("resource count too wide");
	property p_short_width; rd && paddr == 12'h020 |-> prdata[31:8] == 24'h0; endproperty
	a_short_width: assert property (p_short_width) else $error("undersize count too wide");
	property p_fcs; fcs_align_err |-> rx_done; endproperty
	a_fcs: assert property (p_fcs) else $error("stray fcs");
	property p_fin; sym && rx_length >= 14'h40 && rx_length <= 14'h5EE |-> fcs_align_err; endproperty
	a_fin: assert property (p_fin) else $error("no fcs");
	property p_jab; sym && rx_length > 14'h600 |-> !fcs_align_err; endproperty
	a_jab: assert property (p_jab) else $error("jabber as fcs");
	property p_err; psel && penable && paddr > 12'h034 |-> pslverr ##1 !pslverr; endproperty
	a_err: assert property (p_err) else $error("slverr");
	property p_rst; $rose(presetn) |-> prdata == 32'h0 && !irq; endproperty
	a_rst: assert property (p_rst) else $error("reset value");
	c_sym: cover property (sym);
	c_fcs: cover property (fcs_align_err);
	c_irq: cover property ($rose(irq));
endmodule // mac_stat_chk
bind mac_error_statistics_counters mac_stat_chk u_chk (.*);

// >>> test/mac_frame_src.sv
`timescale 1ns/1ps
module mac_frame_src (
	input wire pclk,
	output reg tx_done, tx_excess_col, tx_underrun, tx_any_col, tx_crs_lost, tx_en, col,
	output reg rx_done, rx_addr_match, rx_no_buffer, rx_overrun, rx_symbol_err, rx_crc_err,
	output reg rx_align_err,
	output reg [13:0] rx_length,
	output reg [15:0] rx_len_type
);
	initial {tx_done, tx_excess_col, tx_underrun, tx_any_col, tx_crs_lost, tx_en, col} = 7'h0;
	initial {rx_done, rx_addr_match, rx_no_buffer, rx_overrun, rx_symbol_err, rx_crc_err,
		rx_align_err, rx_length, rx_len_type} = 37'h0;
	// Qualifiers go inverted once the frame strobe drops
	task tx(input [3:0] f);
		@(posedge pclk);
		tx_done <= 1'b1;
		{tx_excess_col, tx_underrun, tx_any_col, tx_crs_lost} <= f;
		@(posedge pclk);
		tx_done <= 1'b0;
		{tx_excess_col, tx_underrun, tx_any_col, tx_crs_lost} <= ~f;
	endtask
	task rx(input [5:0] f, input [13:0] n, input [15:0] t);
		@(posedge pclk);
		rx_done <= 1'b1;
		{rx_addr_match, rx_no_buffer, rx_overrun, rx_symbol_err, rx_crc_err, rx_align_err,
			rx_length, rx_len_type} <= {f, n, t};
		@(posedge pclk);
		rx_done <= 1'b0;
		{rx_addr_match, rx_no_buffer, rx_overrun, rx_symbol_err, rx_crc_err, rx_align_err,
			rx_length, rx_len_type} <= ~{f, n, t};
	endtask
	task sqe(input c);
		@(posedge pclk);
		tx_en <= 1'b1;
		repeat (4) @(posedge pclk);
		tx_en <= 1'b0;
		repeat (3) @(posedge pclk);
		col <= c;
		@(posedge pclk);
		col <= 1'b0;
		repeat (16) @(posedge pclk);
	endtask
endmodule // mac_frame_src

// >>> test/mac_error_statistics_counters_tb.sv
`timescale 1ns/1ps
module mac_error_statistics_counters_tb;
	typedef struct packed {
		logic [2:0] c;
		logic [5:0] f;
		logic [13:0] n;
		logic [15:0] t;
		logic [3:0] b1, b2;
	} row_t;
	// Config {length check, long frames, half duplex}; b1/b2 counters bumped, F for none
	row_t rows [15] = '{'{3'h1, 6'h0A, 14'h0, 16'h0, 4'h0, 4'hF},
		'{3'h1, 6'h0D, 14'h0, 16'h0, 4'h1, 4'hF}, '{3'h1, 6'h01, 14'h0, 16'h0, 4'h2, 4'hF},
		'{3'h0, 6'h01, 14'h0, 16'h0, 4'hF, 4'hF}, '{3'h1, 6'h03, 14'h0, 16'h0, 4'hF, 4'hF},
		'{3'h0, 6'h30, 14'h64, 16'h800, 4'h3, 4'hF}, '{3'h0, 6'h28, 14'h64, 16'h800, 4'h4, 4'hF},
		'{3'h0, 6'h24, 14'h64, 16'h800, 4'h5, 4'hF}, '{3'h0, 6'h24, 14'h5EF, 16'h800, 4'h5, 4'h7},
		'{3'h0, 6'h20, 14'h5EF, 16'h800, 4'h6, 4'hF}, '{3'h2, 6'h20, 14'h5EF, 16'h800, 4'hF, 4'hF},
		'{3'h2, 6'h22, 14'h601, 16'h800, 4'h7, 4'hF}, '{3'h0, 6'h20, 14'h3F, 16'h800, 4'h8, 4'hF},
		'{3'h4, 6'h20, 14'h64, 16'hC8, 4'hA, 4'hF}, '{3'h4, 6'h20, 14'h5EF, 16'h5FA, 4'h6, 4'hF}};
	logic pclk = 1'b0, presetn, psel, penable, pwrite, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, q, e [11];
	wire [31:0] prdata;
	wire pready, pslverr, irq, fcs_align_err, tx_done, tx_excess_col, tx_underrun, tx_any_col;
	wire tx_crs_lost, tx_en, col, rx_done, rx_addr_match, rx_no_buffer, rx_overrun, rx_crc_err;
	wire rx_symbol_err, rx_align_err;
	wire [13:0] rx_length;
	wire [15:0] rx_len_type;
	int mismatches = 0, n_tests = 0, j;
	always #2.5 pclk = ~pclk;
	mac_frame_src u_far (.*);
	mac_error_statistics_counters #(.SQE_CYCLES(8)) u_dut (.*);
	task chk(input [31:0] g, input [31:0] x);
		n_tests++;
		if (g !== x) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task rd(input [11:0] a, input [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
	endtask
	task conclude;
		$display("Checks %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} <= 48'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (j = 0; j < 11; j++) begin
			e[j] = 32'h0;
			rd(12'(j * 4), 32'h0);
		end
		foreach (rows[i]) begin
			apb(1'b1, 12'h02C, {15'h0, rows[i].c[2], 7'h0, rows[i].c[1], 7'h0, rows[i].c[0]});
			if (rows[i].f[5]) u_far.rx(rows[i].f, rows[i].n, rows[i].t);
			else u_far.tx(rows[i].f[3:0]);
			if (rows[i].b1 != 4'hF) e[rows[i].b1]++;
			if (rows[i].b2 != 4'hF) e[rows[i].b2]++;
			for (j = 0; j < 11; j++) rd(12'(j * 4), e[j]);
		end
		apb(1'b1, 12'h000, 32'h123456FE);
		rd(12'h000, 32'hFE);
		u_far.tx(4'hA);
		u_far.tx(4'hA);
		rd(12'h000, 32'h0);
		apb(1'b1, 12'h02C, 32'h1);
		u_far.sqe(1'b0);
		u_far.sqe(1'b1);
		apb(1'b1, 12'h02C, 32'h0);
		u_far.sqe(1'b0);
		rd(12'h024, 32'h1);
		rd(12'h030, 32'h7FF);
		rd(12'h030, 32'h0);
		apb(1'b1, 12'h034, 32'h2);
		u_far.tx(4'h4);
		@(posedge pclk);
		chk(irq, 32'h1);
		rd(12'h030, 32'h2);
		@(posedge pclk);
		chk(irq, 32'h0);
		apb(1'b1, 12'h034, 32'h1);
		u_far.tx(4'h4);
		@(posedge pclk);
		chk(irq, 32'h0);
		apb(1'b1, 12'h040, 32'hFFFFFFFF);
		chk(err, 32'h1);
		rd(12'h040, 32'h0);
		conclude;
	end
	initial begin
		#200000;
		mismatches++;
		conclude;
	end
endmodule // mac_error_statistics_counters_tb
